// ==== bench/pifs_host_model.sv ====
`timescale 1ns/1ps
module pifs_host_model (
	// bus pins
	output logic scl,
	output logic sda,
	input wire logic sdaWire,
	// acknowledge outcome of the last frame
	output logic nacks
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nacks = 1'b0;
	end
	// the clock stands high between frames; 320 ns period
	task automatic bit9(input logic b, input logic ack);
		sda = b;
		#160 scl = 1'b1;
		#80 if (ack && sdaWire) nacks = 1'b1;
		#80 scl = 1'b0;
	endtask
	// a clock pulse with no start: looks like a transfer cut short
	task automatic glitch();
		#160 scl = 1'b0;
		#160 scl = 1'b1;
		#160;
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
		logic [23:0] w;
		w = {a, c, d};
		nacks = 1'b0;
		#160 sda = 1'b0;
		#160 scl = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			bit9(w[i], 1'b0);
			if (i % 8 == 0) bit9(1'b1, 1'b1);
		end
		sda = 1'b0;
		#160 scl = 1'b1;
		#160 sda = 1'b1;
	endtask
endmodule

// ==== bench/power_init_fault_supervisor_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module power_init_fault_supervisor_tb_top;
	logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic initDone = 0, core3v3InWindow = 0, mainInputAboveOn = 0, mainInputBelowOff = 0;
	logic [1:0] overvoltage = 0, undervoltage = 0, overcurrent = 0, overtemperature = 0;
	logic [1:0] timingFault = 0, powerOk = 0, pwmHigh = 0, highSideGate, lowSideGate;
	logic [1:0] faultLineIn, faultLineOut, faultLineOe_n, powerGoodLineOut, powerGoodLineOe_n;
	logic [1:0] channelOnLineOut, channelOnLineOe_n;
	logic pready, pslverr, switchEnable, adcValid, syncOut, syncOe_n, shareTimebaseOut, err;
	logic shareTimebaseOe_n, alertOut, alertOe_n, sclIn, sclOut, sclOe_n, sdaIn, sdaOut, sdaOe_n;
	logic irq, scl, sda, nacks;
	logic [1:0] extPull = 2'b00;
	int n_errors = 0, n_tests = 0, hi = 0, lo = 0;
	always #20 core_clk = ~core_clk;
	// every open-drain wire is pulled up
	assign faultLineIn = faultLineOe_n & ~extPull;
	assign sclIn = scl & sclOe_n;
	assign sdaIn = sda & sdaOe_n;
	pifs_top pifs_top_inst (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .initDone, .core3v3InWindow, .mainInputAboveOn,
		.mainInputBelowOff, .overvoltage, .undervoltage, .overcurrent, .overtemperature,
		.timingFault, .powerOk, .pwmHigh, .highSideGate, .lowSideGate, .switchEnable, .adcValid,
		.faultLineIn, .faultLineOut, .faultLineOe_n, .syncOut, .syncOe_n, .shareTimebaseOut,
		.shareTimebaseOe_n, .powerGoodLineOut, .powerGoodLineOe_n, .channelOnLineOut,
		.channelOnLineOe_n, .alertOut, .alertOe_n, .sclIn, .sclOut, .sclOe_n, .sdaIn, .sdaOut,
		.sdaOe_n, .irq);
	pifs_host_model pifs_host_model_inst (.scl, .sda, .sdaWire(sdaIn), .nacks);
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
		if (pready !== 1'b1)
			n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		end_of_test;
	end
	initial begin
		wt(5);
		reset_n <= 1'b1;
		apb(0, 8'h00, 0);
		`CHK("ctrl", 32'h0000040d, rd)
		apb(0, 8'h08, 0);
		`CHK("retry", 32'h000000fa, rd)
		apb(0, 8'h1c, 0);
		`CHK("unmapped", 1'b1, err)
		apb(0, 8'h0c, 0);
		`CHK("notinit", 1'b0, rd[3])
		initDone <= 1'b1;
		wt(10);
		`CHK("runhold", 2'b00, channelOnLineOe_n)
		core3v3InWindow <= 1'b1;
		wt(10);
		`CHK("runfree", 2'b11, channelOnLineOe_n)
		pifs_host_model_inst.frame(8'h80, 8'h00, 8'h00);
		`CHK("cfgnack", 1'b1, nacks)
		pifs_host_model_inst.frame(8'hb6, 8'hbd, 8'h2b);
		pifs_host_model_inst.frame(8'hb6, 8'hbd, 8'h11);
		pifs_host_model_inst.frame(8'hb6, 8'hbd, 8'hc4);
		apb(0, 8'h0c, 0);
		`CHK("broken", 1'b0, rd[3])
		`CHK("masked", 1'b0, irq)
		pifs_host_model_inst.frame(8'hb6, 8'hbd, 8'h2b);
		pifs_host_model_inst.frame(8'hb6, 8'hbd, 8'hc4);
		apb(0, 8'h0c, 0);
		`CHK("unlocked", 1'b1, rd[3])
		apb(1, 8'h18, 32'h10);
		wt(3);
		`CHK("irqset", 1'b1, irq)
		apb(1, 8'h14, 32'h10);
		wt(3);
		`CHK("irqclr", 1'b0, irq)
		mainInputAboveOn <= 1'b1;
		wt(20);
		`CHK("waitrst", 1'b0, switchEnable)
		`CHK("adcoff", 1'b0, adcValid)
		pifs_host_model_inst.frame(8'h80, 8'hfd, 8'h00);
		`CHK("cfgack", 1'b0, nacks)
		wt(20);
		`CHK("running", 1'b1, switchEnable)
		`CHK("adcon", 1'b1, adcValid)
		overvoltage <= 2'b01;
		wt(6);
		`CHK("ovgate", 2'b10, {highSideGate[0], lowSideGate[0]})
		mainInputAboveOn <= 1'b0;
		mainInputBelowOff <= 1'b1;
		wt(6);
		repeat (300) begin
			@(posedge core_clk);
			hi += shareTimebaseOe_n;
			lo += !syncOe_n;
		end
		`CHK("share", 0, hi)
		`CHK("sync", 78, lo)
		overvoltage <= 2'b00;
		extPull <= 2'b10;
		apb(1, 8'h00, 32'h00000406);
		wt(2);
		`CHK("alertoff", 1'b1, alertOe_n)
		mainInputBelowOff <= 1'b0;
		mainInputAboveOn <= 1'b1;
		wt(6);
		`CHK("pwrflt", 1'b0, alertOe_n)
		apb(0, 8'h0c, 0);
		`CHK("rstate", 3'h5, rd[6:4])
		pifs_host_model_inst.glitch();
		apb(0, 8'h10, 0);
		`CHK("cml", 1'b1, rd[0])
		end_of_test;
	end
endmodule

// ==== rtl/pifs_bus_if.sv ====
`timescale 1ns/1ps
interface pifs_bus_if;
	logic notInit;
	logic [6:0] cfgAddr;
	logic byteStb;
	logic [1:0] byteIdx;
	logic [7:0] byteVal;
	logic [6:0] addr;
	logic communication_fault;
	modport rx (input notInit, cfgAddr, output byteStb, byteIdx, byteVal, addr, communication_fault);
	modport core (output notInit, cfgAddr, input byteStb, byteIdx, byteVal, addr, communication_fault);
endinterface

// ==== rtl/pifs_bus_rx.sv ====
`timescale 1ns/1ps
`include "pifs_consts.svh"
module pifs_bus_rx (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// serial pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOe_n,
	// core side
	pifs_bus_if.rx bus
);
	logic [1:0] sclSync, sdaSync;
	logic sclD, sdaD, active, addrOk, hit;
	logic [3:0] bitCnt;
	logic [1:0] idx;
	logic [7:0] shift;
	logic rise, fall, start, stop;

	// idle bus is high; resetting the samplers high avoids a false edge at release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			sclD <= sclSync[1];
			sdaD <= sdaSync[1];
		end
	end

	assign rise = sclSync[1] & !sclD;
	assign fall = !sclSync[1] & sclD;
	assign start = sclSync[1] & sclD & sdaD & !sdaSync[1];
	assign stop = sclSync[1] & sclD & !sdaD & sdaSync[1];
	assign hit = bus.notInit ?
		(shift[7:1] == `PIFS_ADDR_FIXED || shift[7:1] == `PIFS_ADDR_GLOBAL) :
		(shift[7:1] == bus.cfgAddr || shift[7:1] == `PIFS_ADDR_GLOBAL);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			active <= 1'b0;
			addrOk <= 1'b0;
			bitCnt <= 4'h0;
			idx <= 2'h0;
			shift <= 8'h00;
			sdaOe_n <= 1'b1;
			bus.byteStb <= 1'b0;
			bus.byteIdx <= 2'h0;
			bus.byteVal <= 8'h00;
			bus.addr <= 7'h00;
			bus.communication_fault <= 1'b0;
		end else begin
			bus.byteStb <= 1'b0;
			bus.communication_fault <= 1'b0;
			if (start) begin
				active <= 1'b1;
				bitCnt <= 4'h0;
				idx <= 2'h0;
				sdaOe_n <= 1'b1;
			end else if (stop) begin
				active <= 1'b0;
				sdaOe_n <= 1'b1;
				bus.communication_fault <= !active;
			end else if (rise) begin
				if (!active) begin
					bus.communication_fault <= 1'b1;
				end else if (bitCnt < 4'h8) begin
					shift <= {shift[6:0], sdaSync[1]};
					bitCnt <= bitCnt + 4'h1;
				end
			end else if (fall && active) begin
				if (bitCnt == 4'h8) begin
					bitCnt <= 4'h9;
					if (idx == 2'h0) begin
						// only writes are acknowledged
						addrOk <= hit & !shift[0];
						bus.addr <= shift[7:1];
						sdaOe_n <= !(hit & !shift[0]);
					end else begin
						sdaOe_n <= !addrOk;
						bus.byteStb <= addrOk;
						bus.byteVal <= shift;
						bus.byteIdx <= idx;
					end
				end else if (bitCnt == 4'h9) begin
					sdaOe_n <= 1'b1;
					bitCnt <= 4'h0;
					if (idx != 2'h3) begin
						idx <= idx + 2'h1;
					end
				end
			end
		end
	end

	property p_fixed_addr;
		@(posedge core_clk) disable iff (!reset_n)
		(fall && active && !start && !stop && bitCnt == 4'h8 && idx == 2'h0 && bus.notInit
			&& shift[7:1] != `PIFS_ADDR_FIXED && shift[7:1] != `PIFS_ADDR_GLOBAL) |=> sdaOe_n;
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("acked a foreign address");
endmodule

// ==== rtl/pifs_consts.svh ====
`ifndef PIFS_CONSTS_SVH
`define PIFS_CONSTS_SVH
// timing
`define PIFS_CLK_NS 40
`define PIFS_SYNC_LOW_NS 500
`define PIFS_SYNC_PERIOD_NS 2000
`define PIFS_SHARE_PERIOD_NS 10000
`define PIFS_SHARE_LOW_NS 1000
`define PIFS_CYC_UP(t) (((t) + `PIFS_CLK_NS - 1) / `PIFS_CLK_NS)
`define PIFS_CYC_DN(t) ((t) / `PIFS_CLK_NS)
// register offsets
`define PIFS_OFF_CTRL 8'h00
`define PIFS_OFF_FSEL 8'h04
`define PIFS_OFF_RETRY 8'h08
`define PIFS_OFF_COMMON 8'h0c
`define PIFS_OFF_ISTAT 8'h10
`define PIFS_OFF_ICLR 8'h14
`define PIFS_OFF_IEN 8'h18
// field positions
`define PIFS_CTRL_RESP 0
`define PIFS_CTRL_SYNCEN 2
`define PIFS_CTRL_ALERTF 3
`define PIFS_CTRL_ADDR 4
`define PIFS_COMMON_NOTINIT 3
`define PIFS_INT_CML 0
`define PIFS_INT_PWRFLT 1
`define PIFS_INT_FAULT 2
`define PIFS_INT_VINLOSS 3
`define PIFS_INT_UNLOCK 4
`define PIFS_INT_RESTART 5
`define PIFS_INT_W 6
// reset values
`define PIFS_RESP_RST 2'h1
`define PIFS_SYNCEN_RST 1'h1
`define PIFS_ALERTF_RST 1'h1
`define PIFS_ADDR_RST 7'h40
`define PIFS_FSEL_RST 5'h1f
`define PIFS_RETRY_RST 16'h00fa
`define PIFS_IEN_RST 6'h00
// management bus codes
`define PIFS_ADDR_FIXED 7'h5a
`define PIFS_ADDR_GLOBAL 7'h5b
`define PIFS_UNLOCK_CMD 8'hbd
`define PIFS_UNLOCK_D1 8'h2b
`define PIFS_UNLOCK_D2 8'hc4
`define PIFS_RESTART_CMD 8'hfd
`endif

// ==== rtl/pifs_pkg.sv ====
package pifs_pkg;
	typedef enum logic [2:0] {
		ST_HOLD = 3'b000,
		ST_WAIT_VIN = 3'b001,
		ST_WAIT_RST = 3'b010,
		ST_RUN = 3'b011,
		ST_LATCH = 3'b100,
		ST_RETRY = 3'b101
	} pifs_seq_t;
	typedef enum logic [1:0] {
		RESP_IGNORE = 2'b00,
		RESP_LATCH = 2'b01,
		RESP_RETRY = 2'b10
	} pifs_resp_t;
endpackage

// ==== rtl/pifs_pulse_gen.sv ====
`timescale 1ns/1ps
module pifs_pulse_gen #(
	parameter int PERIOD = 50,
	parameter int LOW = 13
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	input wire logic forceLow,
	// pin
	output logic pinOe_n
);
	localparam int CW = $clog2(PERIOD + 1);
	logic [CW-1:0] cnt, lowRun;
	logic cleanRun;

	if (LOW < 1 || LOW >= PERIOD) begin : g_bad
		$error("pulse low time must be shorter than its period");
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
		end else if (!enable || forceLow) begin
			cnt <= '0;
		end else begin
			cnt <= (cnt == CW'(PERIOD - 1)) ? '0 : CW'(cnt + 1'b1);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinOe_n <= 1'b1;
		end else begin
			pinOe_n <= !(forceLow || (enable && cnt < CW'(LOW)));
		end
	end

	// helper for the pulse-length check below
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lowRun <= '0;
			cleanRun <= 1'b1;
		end else begin
			lowRun <= pinOe_n ? '0 : CW'(lowRun + 1'b1);
			cleanRun <= pinOe_n ? 1'b1 : (cleanRun & enable & !forceLow);
		end
	end

	property p_low_len;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(pinOe_n) && cleanRun |-> lowRun == CW'(LOW);
	endproperty
	a_low_len: assert property (p_low_len) else $error("pulse low time wrong");
endmodule

// ==== rtl/pifs_top.sv ====
`timescale 1ns/1ps
`include "pifs_consts.svh"
// Operation
// - hold the run line low until init done and core 3v3 in window
// - start sequencing only after main input exceeds its on threshold
// - input below off threshold pulls shared timebase low until back above on
// - fault line low when main input appears forces alert, ignoring masking
// - a bus transaction seen only in part records a comm fault, asserts alert
// - common status word bit 3 reads low while main input never applied and no unlock taken
// - while uninitialised answer only the two fixed addresses
// - 0x2b then 0xc4 to command 0xbd at global address unlocks configured address
// - after standalone programming stay disabled until soft restart command
// - fault line selectable per fault kind and sensed when pulled low outside
// - fault response is ignore, latch off, or retry forever at retry interval
// - overvoltage always forces high-side gate on and low-side gate off
// - open-drain pins are only ever pulled low, never driven high
// - sync line low for nominally 500ns each oscillator cycle
// - shared timebase pulses 10us period, low for 1us each period
module pifs_top #(
	parameter int NCH = 2,
	parameter int SYNC_PERIOD = `PIFS_CYC_DN(`PIFS_SYNC_PERIOD_NS)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// supply monitors
	input wire logic initDone,
	input wire logic core3v3InWindow,
	input wire logic mainInputAboveOn,
	input wire logic mainInputBelowOff,
	// fault detectors
	input wire logic [NCH-1:0] overvoltage,
	input wire logic [NCH-1:0] undervoltage,
	input wire logic [NCH-1:0] overcurrent,
	input wire logic [NCH-1:0] overtemperature,
	input wire logic [NCH-1:0] timingFault,
	input wire logic [NCH-1:0] powerOk,
	// control loop
	input wire logic [NCH-1:0] pwmHigh,
	output logic [NCH-1:0] highSideGate,
	output logic [NCH-1:0] lowSideGate,
	output logic switchEnable,
	output logic adcValid,
	// open-drain pins
	input wire logic [NCH-1:0] faultLineIn,
	output logic [NCH-1:0] faultLineOut,
	output logic [NCH-1:0] faultLineOe_n,
	output logic syncOut,
	output logic syncOe_n,
	output logic shareTimebaseOut,
	output logic shareTimebaseOe_n,
	output logic [NCH-1:0] powerGoodLineOut,
	output logic [NCH-1:0] powerGoodLineOe_n,
	output logic [NCH-1:0] channelOnLineOut,
	output logic [NCH-1:0] channelOnLineOe_n,
	output logic alertOut,
	output logic alertOe_n,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe_n,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	// interrupt
	output logic irq
);
	localparam int AW = 4 + 7 * NCH;
	localparam int SYNC_LOW = `PIFS_CYC_UP(`PIFS_SYNC_LOW_NS);
	localparam int SHARE_PERIOD = `PIFS_CYC_DN(`PIFS_SHARE_PERIOD_NS);
	localparam int SHARE_LOW = `PIFS_CYC_UP(`PIFS_SHARE_LOW_NS);

	if (NCH < 1 || SYNC_PERIOD <= SYNC_LOW) begin : g_bad
		$error("unsupported channel count or sync period");
	end

	function automatic logic isMapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= `PIFS_OFF_IEN;
	endfunction

	logic [AW-1:0] asyncS1, asyncS2;
	logic initS, coreOkS, vinOnS, vinOffS, vinOnD, vinLow;
	logic [NCH-1:0] ovS, uvS, ocS, otS, tmS, pokS, fltPinS;
	logic [NCH-1:0] intFault, extFault;
	logic [2:0] drvHist [NCH];
	logic faultAny, faultAnyD;
	pifs_pkg::pifs_resp_t resp;
	logic syncEn, alertOnFault;
	logic [6:0] busAddr;
	logic [4:0] faultSel;
	logic [15:0] retryInterval, retryCnt;
	logic [`PIFS_INT_W-1:0] intStatus, intEnable, intEvents, intClear;
	logic [31:0] rdVal, commonWord;
	logic apbSetup, apbWr;
	logic notInit, needRestart, armed, unlockStb, restartStb;
	logic [7:0] lastCmd;
	pifs_pkg::pifs_seq_t seqState;
	logic zeroOut, relOe_n;

	pifs_bus_if bus();
	assign bus.notInit = notInit;
	assign bus.cfgAddr = busAddr;

	pifs_bus_rx u_rx (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sdaOe_n(sdaOe_n),
		.bus(bus)
	);

	pifs_pulse_gen #(.PERIOD(SYNC_PERIOD), .LOW(SYNC_LOW)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.enable(syncEn && seqState != pifs_pkg::ST_HOLD),
		.forceLow(1'b0),
		.pinOe_n(syncOe_n)
	);

	pifs_pulse_gen #(.PERIOD(SHARE_PERIOD), .LOW(SHARE_LOW)) u_share (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.enable(seqState != pifs_pkg::ST_HOLD),
		.forceLow(vinLow),
		.pinOe_n(shareTimebaseOe_n)
	);

	// every pin below only sinks current; the level driven is always low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			zeroOut <= 1'b0;
			relOe_n <= 1'b1;
		end else begin
			zeroOut <= 1'b0;
			relOe_n <= 1'b1;
		end
	end
	assign faultLineOut = {NCH{zeroOut}};
	assign syncOut = zeroOut;
	assign shareTimebaseOut = zeroOut;
	assign powerGoodLineOut = {NCH{zeroOut}};
	assign channelOnLineOut = {NCH{zeroOut}};
	assign alertOut = zeroOut;
	assign sclOut = zeroOut;
	assign sdaOut = zeroOut;
	assign sclOe_n = relOe_n;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			asyncS1 <= '0;
			asyncS2 <= '0;
		end else begin
			asyncS1 <= {initDone, core3v3InWindow, mainInputAboveOn, mainInputBelowOff,
				overvoltage, undervoltage, overcurrent, overtemperature, timingFault,
				powerOk, faultLineIn};
			asyncS2 <= asyncS1;
		end
	end
	assign {initS, coreOkS, vinOnS, vinOffS, ovS, uvS, ocS, otS, tmS, pokS, fltPinS} = asyncS2;

	// own drive reaches the sampler three edges later, so only a quiet history counts
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			intFault[c] = |(faultSel & {tmS[c], otS[c], ocS[c], uvS[c], ovS[c]});
			extFault[c] = !fltPinS[c] && drvHist[c] == 3'h0 && seqState != pifs_pkg::ST_HOLD;
		end
	end
	assign faultAny = |{intFault, extFault};

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			faultLineOe_n <= '1;
			for (int c = 0; c < NCH; c++) begin
				drvHist[c] <= 3'h0;
			end
		end else begin
			faultLineOe_n <= ~intFault;
			for (int c = 0; c < NCH; c++) begin
				drvHist[c] <= {drvHist[c][1:0], !faultLineOe_n[c]};
			end
		end
	end

	// register bus
	assign apbSetup = psel & !penable;
	assign apbWr = psel & penable & pready & pwrite;
	assign intClear = (apbWr && paddr == `PIFS_OFF_ICLR) ? pwdata[`PIFS_INT_W-1:0] : '0;
	assign commonWord = {24'h0, needRestart, seqState, !notInit, vinOnS, switchEnable,
		seqState == pifs_pkg::ST_RUN};

	always_comb begin
		case (paddr)
			`PIFS_OFF_CTRL: rdVal = {21'h0, busAddr, alertOnFault, syncEn, resp};
			`PIFS_OFF_FSEL: rdVal = {27'h0, faultSel};
			`PIFS_OFF_RETRY: rdVal = {16'h0, retryInterval};
			`PIFS_OFF_COMMON: rdVal = commonWord;
			`PIFS_OFF_ISTAT: rdVal = {{(32 - `PIFS_INT_W){1'b0}}, intStatus};
			`PIFS_OFF_IEN: rdVal = {{(32 - `PIFS_INT_W){1'b0}}, intEnable};
			default: rdVal = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup & !isMapped(paddr);
			prdata <= (apbSetup && !pwrite && isMapped(paddr)) ? rdVal : 32'h0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			resp <= pifs_pkg::pifs_resp_t'(`PIFS_RESP_RST);
			syncEn <= `PIFS_SYNCEN_RST;
			alertOnFault <= `PIFS_ALERTF_RST;
			busAddr <= `PIFS_ADDR_RST;
			faultSel <= `PIFS_FSEL_RST;
			retryInterval <= `PIFS_RETRY_RST;
			intEnable <= `PIFS_IEN_RST;
		end else if (apbWr) begin
			if (paddr == `PIFS_OFF_CTRL) begin
				resp <= pifs_pkg::pifs_resp_t'(pwdata[`PIFS_CTRL_RESP+:2]);
				syncEn <= pwdata[`PIFS_CTRL_SYNCEN];
				alertOnFault <= pwdata[`PIFS_CTRL_ALERTF];
				busAddr <= pwdata[`PIFS_CTRL_ADDR+:7];
			end
			if (paddr == `PIFS_OFF_FSEL) begin
				faultSel <= pwdata[4:0];
			end
			if (paddr == `PIFS_OFF_RETRY) begin
				retryInterval <= pwdata[15:0];
			end
			if (paddr == `PIFS_OFF_IEN) begin
				intEnable <= pwdata[`PIFS_INT_W-1:0];
			end
		end
	end

	// events; a new event wins over a clear in the same cycle
	always_comb begin
		intEvents = '0;
		intEvents[`PIFS_INT_CML] = bus.communication_fault;
		intEvents[`PIFS_INT_PWRFLT] = vinOnS & !vinOnD & (|(~fltPinS));
		intEvents[`PIFS_INT_FAULT] = faultAny & !faultAnyD;
		intEvents[`PIFS_INT_VINLOSS] = vinOffS & !vinLow & seqState != pifs_pkg::ST_HOLD;
		intEvents[`PIFS_INT_UNLOCK] = unlockStb;
		intEvents[`PIFS_INT_RESTART] = restartStb;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			intStatus <= '0;
			vinOnD <= 1'b0;
			faultAnyD <= 1'b0;
			irq <= 1'b0;
			alertOe_n <= 1'b1;
		end else begin
			intStatus <= (intStatus & ~intClear) | intEvents;
			vinOnD <= vinOnS;
			faultAnyD <= faultAny;
			irq <= |(intStatus & intEnable);
			alertOe_n <= !(intStatus[`PIFS_INT_CML] | intStatus[`PIFS_INT_PWRFLT]
				| (intStatus[`PIFS_INT_FAULT] & alertOnFault));
		end
	end

	// management bus commands
	always_comb begin
		unlockStb = 1'b0;
		restartStb = 1'b0;
		if (bus.byteStb && bus.byteIdx == 2'h2 && bus.addr == `PIFS_ADDR_GLOBAL
			&& lastCmd == `PIFS_UNLOCK_CMD) begin
			unlockStb = armed && bus.byteVal == `PIFS_UNLOCK_D2;
		end
		if (bus.byteStb && bus.byteIdx == 2'h1 && !notInit) begin
			restartStb = bus.byteVal == `PIFS_RESTART_CMD;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lastCmd <= 8'h00;
			armed <= 1'b0;
			notInit <= 1'b1;
			needRestart <= 1'b0;
			vinLow <= 1'b0;
		end else begin
			if (bus.byteStb) begin
				if (bus.byteIdx == 2'h1) begin
					lastCmd <= bus.byteVal;
					armed <= armed && bus.addr == `PIFS_ADDR_GLOBAL
						&& bus.byteVal == `PIFS_UNLOCK_CMD;
				end else begin
					armed <= bus.byteIdx == 2'h2 && bus.addr == `PIFS_ADDR_GLOBAL
						&& lastCmd == `PIFS_UNLOCK_CMD
						&& bus.byteVal == `PIFS_UNLOCK_D1;
				end
			end
			if (unlockStb || vinOnS) begin
				notInit <= 1'b0;
			end
			if (unlockStb) begin
				needRestart <= 1'b1;
			end else if (restartStb) begin
				needRestart <= 1'b0;
			end
			if (vinOffS) begin
				vinLow <= 1'b1;
			end else if (vinOnS) begin
				vinLow <= 1'b0;
			end
		end
	end

	// power sequencing
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			seqState <= pifs_pkg::ST_HOLD;
			retryCnt <= 16'h0;
		end else if (seqState != pifs_pkg::ST_HOLD && vinOffS) begin
			seqState <= pifs_pkg::ST_WAIT_VIN;
		end else begin
			unique case (seqState)
				pifs_pkg::ST_HOLD: begin
					if (initS && coreOkS) begin
						seqState <= pifs_pkg::ST_WAIT_VIN;
					end
				end
				pifs_pkg::ST_WAIT_VIN: begin
					if (vinOnS) begin
						seqState <= needRestart ? pifs_pkg::ST_WAIT_RST : pifs_pkg::ST_RUN;
					end
				end
				pifs_pkg::ST_WAIT_RST: begin
					if (restartStb) begin
						seqState <= pifs_pkg::ST_RUN;
					end
				end
				pifs_pkg::ST_RUN: begin
					if (faultAny && resp == pifs_pkg::RESP_LATCH) begin
						seqState <= pifs_pkg::ST_LATCH;
					end else if (faultAny && resp == pifs_pkg::RESP_RETRY) begin
						seqState <= pifs_pkg::ST_RETRY;
						retryCnt <= retryInterval;
					end
				end
				pifs_pkg::ST_LATCH: begin
					if (restartStb) begin
						seqState <= pifs_pkg::ST_WAIT_VIN;
					end
				end
				pifs_pkg::ST_RETRY: begin
					if (retryCnt == 16'h0) begin
						seqState <= pifs_pkg::ST_WAIT_VIN;
					end else begin
						retryCnt <= retryCnt - 16'h1;
					end
				end
				default: seqState <= pifs_pkg::ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			switchEnable <= 1'b0;
			adcValid <= 1'b0;
			highSideGate <= '0;
			lowSideGate <= '0;
			channelOnLineOe_n <= '0;
			powerGoodLineOe_n <= '0;
		end else begin
			// an unlock while running must stop switching at once, not one edge later
			switchEnable <= seqState == pifs_pkg::ST_RUN && !faultAny && !needRestart
				&& !unlockStb;
			adcValid <= seqState != pifs_pkg::ST_HOLD && !needRestart;
			channelOnLineOe_n <= {NCH{seqState != pifs_pkg::ST_HOLD}};
			powerGoodLineOe_n <= {NCH{seqState == pifs_pkg::ST_RUN}} & pokS;
			for (int c = 0; c < NCH; c++) begin
				highSideGate[c] <= ovS[c] | (switchEnable & pwmHigh[c]);
				lowSideGate[c] <= !ovS[c] & switchEnable & !pwmHigh[c];
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_run_hold;
		(seqState == pifs_pkg::ST_HOLD) [*2] |-> channelOnLineOe_n == '0 && !switchEnable;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run line released early");

	property p_no_start;
		seqState == pifs_pkg::ST_WAIT_VIN && !vinOnS |=> seqState != pifs_pkg::ST_RUN;
	endproperty
	a_no_start: assert property (p_no_start) else $error("started below on threshold");

	property p_vin_loss;
		vinOffS && seqState != pifs_pkg::ST_HOLD |-> ##[1:2] !shareTimebaseOe_n
			##1 seqState == pifs_pkg::ST_WAIT_VIN;
	endproperty
	a_vin_loss: assert property (p_vin_loss) else $error("timebase not held on input loss");

	property p_pwr_fault;
		vinOnS && !vinOnD && (|(~fltPinS)) |-> ##2 !alertOe_n;
	endproperty
	a_pwr_fault: assert property (p_pwr_fault) else $error("alert missed at power-up fault");

	property p_cml;
		bus.communication_fault |-> ##1 intStatus[`PIFS_INT_CML] ##1 !alertOe_n;
	endproperty
	a_cml: assert property (p_cml) else $error("partial transaction not flagged");

	property p_notinit;
		notInit |-> !commonWord[`PIFS_COMMON_NOTINIT] && !$past(vinOnS);
	endproperty
	a_notinit: assert property (p_notinit) else $error("not-initialised flag wrong");

	property p_unlock;
		unlockStb |=> !notInit && needRestart && !armed;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock not taken");

	property p_restart_gate;
		needRestart |-> !switchEnable ##1 !adcValid;
	endproperty
	a_restart_gate: assert property (p_restart_gate) else $error("ran before restart");

	property p_latch;
		seqState == pifs_pkg::ST_RUN && faultAny && !vinOffS && resp == pifs_pkg::RESP_LATCH
			|=> seqState == pifs_pkg::ST_LATCH ##1 !switchEnable;
	endproperty
	a_latch: assert property (p_latch) else $error("fault did not latch off");

	property p_ov_gate;
		ovS[0] |=> highSideGate[0] && !lowSideGate[0];
	endproperty
	a_ov_gate: assert property (p_ov_gate) else $error("overvoltage gate response wrong");

	property p_bad_pair;
		bus.byteStb && bus.byteIdx == 2'h2 && bus.byteVal != `PIFS_UNLOCK_D1
			&& bus.byteVal != `PIFS_UNLOCK_D2 |=> !armed && $stable(notInit);
	endproperty
	a_bad_pair: assert property (p_bad_pair) else $error("broken unlock pair accepted");

	property p_od_level;
		zeroOut == 1'b0 && sclOe_n;
	endproperty
	a_od_level: assert property (p_od_level) else $error("open-drain pin driven high");

	c_unlock: cover property (unlockStb);
	c_retry: cover property (seqState == pifs_pkg::ST_RETRY ##[1:300] seqState == pifs_pkg::ST_RUN);
	c_cml: cover property (bus.communication_fault);
	c_share: cover property ($fell(shareTimebaseOe_n) && seqState == pifs_pkg::ST_RUN);
endmodule
